// ---- inc/pph_pkg.sv ----
package pph_pkg;

	// ==========================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned APP_CYCLE_NS = 1000000;
	localparam int unsigned APP_CYCLE_CLKS = APP_CYCLE_NS / CLK_PERIOD_NS;

	// ==========================================
	// register indices, byte address is four times the index
	localparam logic [15:0] IDX_CTRL = 16'h6040;
	localparam logic [15:0] IDX_STAT = 16'h6041;
	localparam logic [15:0] IDX_HALT_OPT = 16'h605D;
	localparam logic [15:0] IDX_OPSEL = 16'h6060;
	localparam logic [15:0] IDX_FERR_WIN = 16'h6065;
	localparam logic [15:0] IDX_FERR_TMO = 16'h6066;
	localparam logic [15:0] IDX_TOL_WIN = 16'h6067;
	localparam logic [15:0] IDX_DWELL = 16'h6068;
	localparam logic [15:0] IDX_TARGET = 16'h607A;
	localparam logic [15:0] IDX_LIM_MIN = 16'h607D;
	localparam logic [15:0] IDX_LIM_MAX = 16'h6100;
	localparam logic [15:0] IDX_VELOCITY = 16'h6081;
	localparam logic [15:0] IDX_ACCEL = 16'h6083;
	localparam logic [15:0] IDX_DECEL = 16'h6084;
	localparam logic [15:0] IDX_POS_OPT = 16'h60F2;

	// ==========================================
	// control word fields
	localparam int unsigned CW_START = 4;
	localparam int unsigned CW_IMMED = 5;
	localparam int unsigned CW_REL = 6;
	localparam int unsigned CW_HALT = 8;
	localparam int unsigned CW_PASS = 9;

	// status word fields
	localparam int unsigned SW_REACHED = 10;
	localparam int unsigned SW_LIMIT = 11;
	localparam int unsigned SW_ACK = 12;
	localparam int unsigned SW_FERR = 13;

	// ==========================================
	// values and reset values
	localparam logic [7:0] OPSEL_PROFILE_POS = 8'h01;
	localparam logic [1:0] REL_TO_LAST_TARGET = 2'h0;
	localparam logic [1:0] REL_TO_DEMAND = 2'h1;
	localparam logic [1:0] AUTOCLR_ON_ACCEPT = 2'h1;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] OPSEL_RST = 8'h00;
	localparam logic [31:0] LIM_MIN_RST = 32'h80000000;
	localparam logic [31:0] LIM_MAX_RST = 32'h7FFFFFFF;
	localparam logic [31:0] WORD_RST = 32'h00000000;

	// one move handed to the profile generator
	typedef struct packed {
		logic [31:0] target;
		logic [31:0] velocity;
		logic [31:0] accel;
		logic [31:0] decel;
		logic pass_through;
	} pph_move_t;

endpackage

// ---- hw/pph_handler.sv ----
// Functional notes
// RQ1: master writes 1 into operating_selection before issuing positioning commands.
// RQ2: a travel command starts only on a 0 to 1 change of control bit 4.
// RQ3: entering positioning with bit 4 already set starts the command at once.
// RQ4: bit 5 set executes a new command at once, clear waits for current move.
// RQ5: bit 6 selects absolute or relative; reference follows option bits 0 and 1.
// RQ6: bit 8 halts using the halt option, release restarts with start ramp.
// RQ7: bit 9 set and bit 5 clear passes through current target without braking.
// RQ8: bit 9 is ignored when ramp speed cannot be met at the target.
// RQ9: status bit 10 set when last target held inside window for dwell time.
// RQ10: status bit 11 shows demand position outside software limits.
// RQ11: status bit 12 acknowledges a valid set point, following bit 4.
// RQ12: buffered: bit 12 clears when another fits; start while set is dropped.
// RQ13: no acknowledge for unreachable targets or with running and queued targets.
// RQ14: closed loop: bit 13 set when following error exceeds window past timeout.
// RQ15: device may clear bit 4 itself per option bits 4 and 5.
// RQ16: while moving, one further target with its parameters is buffered.
// RQ17: set points arriving while the buffer is full are discarded.
// RQ18: bit 5 set bypasses the buffer and applies commands directly.
// RQ19: bit 9 keeps profile speed to the target; clear finishes the target fully.
// RQ20: option value 0 makes relative targets refer to the preceding target.
// RQ21: command objects and inputs are processed once per 1 ms cycle.
// RQ22: reset empties the buffer and clears ack, reached and following error.
`timescale 1ns/1ps
module pph_handler #(
	parameter int unsigned TICK_CYCLES = pph_pkg::APP_CYCLE_CLKS,
	parameter int unsigned AW = 18
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output pph_pkg::pph_move_t move,
	output logic move_valid,
	output logic halt,
	output logic [15:0] halt_option,
	input wire logic move_busy,
	input wire logic move_done,
	input wire logic ramp_speed_ok,
	input wire logic [31:0] actual_pos,
	input wire logic [31:0] demand_pos,
	input wire logic [31:0] follow_err,
	input wire logic closed_loop
);

	// ==========================================
	// registers
	logic [15:0] ctrl;
	logic [7:0] opsel;
	logic [15:0] pos_opt;
	logic [31:0] target, velocity, accel, decel;
	logic [31:0] lim_min, lim_max, tol_win, dwell, ferr_win, ferr_tmo;
	logic ack, reached, limit_hit, ferr_flag;

	// ==========================================
	// apb decode
	logic [15:0] idx;
	logic mapped;
	logic wr_en;
	logic [31:0] rd_val;

	assign idx = paddr[17:2];
	assign pready = 1'b1;

	// one decode for read data and unmapped detection
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h00000000;
		unique case (idx)
			pph_pkg::IDX_CTRL: rd_val = {16'h0000, ctrl};
			pph_pkg::IDX_STAT: rd_val = {18'h00000, ferr_flag, ack, limit_hit, reached, 10'h000};
			pph_pkg::IDX_HALT_OPT: rd_val = {16'h0000, halt_option};
			pph_pkg::IDX_OPSEL: rd_val = {24'h000000, opsel};
			pph_pkg::IDX_FERR_WIN: rd_val = ferr_win;
			pph_pkg::IDX_FERR_TMO: rd_val = ferr_tmo;
			pph_pkg::IDX_TOL_WIN: rd_val = tol_win;
			pph_pkg::IDX_DWELL: rd_val = dwell;
			pph_pkg::IDX_TARGET: rd_val = target;
			pph_pkg::IDX_LIM_MIN: rd_val = lim_min;
			pph_pkg::IDX_LIM_MAX: rd_val = lim_max;
			pph_pkg::IDX_VELOCITY: rd_val = velocity;
			pph_pkg::IDX_ACCEL: rd_val = accel;
			pph_pkg::IDX_DECEL: rd_val = decel;
			pph_pkg::IDX_POS_OPT: rd_val = {16'h0000, pos_opt};
			default: mapped = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00 || (paddr >> 18) != '0) begin
			mapped = 1'b0;
		end
	end

	assign wr_en = ce && psel && penable && pwrite && mapped;

	// read data captured in setup so it comes from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			prdata <= mapped && !pwrite ? rd_val : 32'h00000000;
		end
	end

	assign pslverr = psel && penable && !mapped;

	// ==========================================
	// application cycle tick
	logic [31:0] tick_cnt;
	logic tick;

	assign tick = (tick_cnt == TICK_CYCLES - 1);

	// RQ21 all command handling rides on this 1 ms strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h00000000;
		end else if (ce) begin
			tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		end
	end

	// ==========================================
	// command decision
	logic active, prev_active, prev_start;
	logic start_evt, tgt_ok, busy_now;
	logic issue_direct, to_buffer, accept, issue_buf;
	logic buf_valid, done_seen;
	logic [31:0] ref_pos, abs_target, last_target;
	pph_pkg::pph_move_t new_move, buf_move;

	assign active = (opsel == pph_pkg::OPSEL_PROFILE_POS);
	// rising edge, or already high while entering positioning
	assign start_evt = tick && active && ctrl[pph_pkg::CW_START]
		&& (!prev_start || !prev_active); // RQ2 RQ3

	// RQ5 RQ20 reference for relative targets
	always_comb begin
		unique case (pos_opt[1:0])
			pph_pkg::REL_TO_LAST_TARGET: ref_pos = last_target;
			pph_pkg::REL_TO_DEMAND: ref_pos = demand_pos;
			default: ref_pos = actual_pos;
		endcase
		abs_target = ctrl[pph_pkg::CW_REL] ? ref_pos + target : target;
	end

	// unreachable targets lie outside the software limits
	assign tgt_ok = $signed(abs_target) >= $signed(lim_min)
		&& $signed(abs_target) <= $signed(lim_max); // RQ13

	assign busy_now = move_busy || move_valid;
	assign new_move.target = abs_target;
	assign new_move.velocity = velocity;
	assign new_move.accel = accel;
	assign new_move.decel = decel;
	// pass through only when the ramp speed holds at the target
	assign new_move.pass_through = ctrl[pph_pkg::CW_PASS] && !ctrl[pph_pkg::CW_IMMED]
		&& ramp_speed_ok; // RQ7 RQ8 RQ19

	// immediate mode skips the buffer, buffered mode queues one entry
	assign issue_direct = start_evt && tgt_ok
		&& (ctrl[pph_pkg::CW_IMMED] || (!busy_now && !buf_valid && !ack)); // RQ4 RQ18
	assign to_buffer = start_evt && tgt_ok && !ctrl[pph_pkg::CW_IMMED]
		&& busy_now && !buf_valid && !ack; // RQ12 RQ16 RQ17
	assign accept = issue_direct || to_buffer;
	assign issue_buf = tick && done_seen && buf_valid && !issue_direct;

	// edge history, sampled once a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_active <= 1'b0;
			prev_start <= 1'b0;
		end else if (ce && tick) begin
			prev_active <= active;
			prev_start <= ctrl[pph_pkg::CW_START];
		end
	end

	// done pulses between ticks are kept until the next tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_seen <= 1'b0;
		end else if (ce) begin
			done_seen <= move_done || (done_seen && !tick);
		end
	end

	// single pending entry, emptied on reset, when handed over, or by bypass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_valid <= 1'b0; // RQ22
			buf_move <= '0;
		end else if (ce) begin
			if (to_buffer) begin
				buf_valid <= 1'b1; // RQ16
				buf_move <= new_move;
			end else if (issue_buf || issue_direct) begin
				buf_valid <= 1'b0; // RQ18
			end
		end
	end

	// move handed to the profile generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			move <= '0;
			move_valid <= 1'b0;
			last_target <= 32'h00000000;
		end else if (ce) begin
			move_valid <= issue_direct || issue_buf;
			if (issue_direct) begin
				move <= new_move; // RQ4
				last_target <= abs_target;
			end else if (issue_buf) begin
				move <= buf_move; // RQ4
				last_target <= buf_move.target;
			end
		end
	end

	// set wins over clear; buffered ack drops once another fits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'b0; // RQ22
		end else if (ce) begin
			if (accept) begin
				ack <= 1'b1; // RQ11
			end else if (tick && (!ctrl[pph_pkg::CW_START]
				|| (!ctrl[pph_pkg::CW_IMMED] && !buf_valid))) begin
				ack <= 1'b0; // RQ11 RQ12
			end
		end
	end

	// ==========================================
	// control registers; software write beats the self clear of bit 4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= pph_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_en && idx == pph_pkg::IDX_CTRL) begin
				ctrl <= pwdata[15:0];
			end else if (accept && pos_opt[5:4] == pph_pkg::AUTOCLR_ON_ACCEPT) begin
				ctrl[pph_pkg::CW_START] <= 1'b0; // RQ15
			end
		end
	end

	// plain parameter registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opsel <= pph_pkg::OPSEL_RST;
			pos_opt <= 16'h0000;
			halt_option <= 16'h0000;
			target <= pph_pkg::WORD_RST;
			velocity <= pph_pkg::WORD_RST;
			accel <= pph_pkg::WORD_RST;
			decel <= pph_pkg::WORD_RST;
			lim_min <= pph_pkg::LIM_MIN_RST;
			lim_max <= pph_pkg::LIM_MAX_RST;
			tol_win <= pph_pkg::WORD_RST;
			dwell <= pph_pkg::WORD_RST;
			ferr_win <= pph_pkg::WORD_RST;
			ferr_tmo <= pph_pkg::WORD_RST;
		end else if (wr_en) begin
			unique case (idx)
				pph_pkg::IDX_OPSEL: opsel <= pwdata[7:0];
				pph_pkg::IDX_POS_OPT: pos_opt <= pwdata[15:0];
				pph_pkg::IDX_HALT_OPT: halt_option <= pwdata[15:0];
				pph_pkg::IDX_TARGET: target <= pwdata;
				pph_pkg::IDX_VELOCITY: velocity <= pwdata;
				pph_pkg::IDX_ACCEL: accel <= pwdata;
				pph_pkg::IDX_DECEL: decel <= pwdata;
				pph_pkg::IDX_LIM_MIN: lim_min <= pwdata;
				pph_pkg::IDX_LIM_MAX: lim_max <= pwdata;
				pph_pkg::IDX_TOL_WIN: tol_win <= pwdata;
				pph_pkg::IDX_DWELL: dwell <= pwdata;
				pph_pkg::IDX_FERR_WIN: ferr_win <= pwdata;
				pph_pkg::IDX_FERR_TMO: ferr_tmo <= pwdata;
				default: ;
			endcase
		end
	end

	// halt level; the generator brakes per halt_option and restarts on release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt <= 1'b0;
		end else if (ce && tick) begin
			halt <= active && ctrl[pph_pkg::CW_HALT]; // RQ6
		end
	end

	// ==========================================
	// status flags, evaluated per cycle
	logic [31:0] pos_diff, pos_dist, dwell_cnt, ferr_cnt;
	logic in_win, all_done, ferr_over;

	assign pos_diff = actual_pos - last_target;
	assign pos_dist = pos_diff[31] ? 32'h00000000 - pos_diff : pos_diff;
	assign in_win = pos_dist <= tol_win;
	assign all_done = !busy_now && !buf_valid;
	assign ferr_over = closed_loop && follow_err > ferr_win;

	// dwell counted in application cycles inside the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dwell_cnt <= 32'h00000000;
			reached <= 1'b0; // RQ22
		end else if (ce && tick) begin
			if (!all_done || !in_win || accept) begin
				dwell_cnt <= 32'h00000000;
				reached <= 1'b0;
			end else if (dwell_cnt >= dwell) begin
				reached <= 1'b1; // RQ9
			end else begin
				dwell_cnt <= dwell_cnt + 32'h00000001;
			end
		end
	end

	// error has to last beyond the timeout, a single spike is tolerated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ferr_cnt <= 32'h00000000;
			ferr_flag <= 1'b0; // RQ22
		end else if (ce && tick) begin
			if (!ferr_over) begin
				ferr_cnt <= 32'h00000000;
				ferr_flag <= 1'b0;
			end else if (ferr_cnt > ferr_tmo) begin
				ferr_flag <= 1'b1; // RQ14
			end else begin
				ferr_cnt <= ferr_cnt + 32'h00000001;
			end
		end
	end

	// demand outside the software window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit_hit <= 1'b0;
		end else if (ce && tick) begin
			limit_hit <= $signed(demand_pos) < $signed(lim_min)
				|| $signed(demand_pos) > $signed(lim_max); // RQ10
		end
	end

	// ==========================================
	// checks
	AST_START_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		(ce && accept) |-> ctrl[pph_pkg::CW_START] && active && tick)
		else $error("move accepted without start bit");

	AST_ENTRY_START: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(ce && tick && active && !prev_active && ctrl[pph_pkg::CW_START]
		&& tgt_ok && ctrl[pph_pkg::CW_IMMED]) |=> move_valid)
		else $error("mode entry with start high did not start");

	AST_IMMEDIATE: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(ce && start_evt && tgt_ok && ctrl[pph_pkg::CW_IMMED])
		|=> move_valid && move.target == $past(abs_target))
		else $error("immediate command not issued next cycle");

	AST_NO_ACK_BAD: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
		(ce && start_evt && !tgt_ok && !ack) |=> !ack)
		else $error("ack given for out of range target");

	AST_FULL_DROP: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
		(ce && start_evt && buf_valid && !ctrl[pph_pkg::CW_IMMED])
		|=> buf_move == $past(buf_move) && (!move_valid || move == $past(buf_move)))
		else $error("full buffer took a new set point");

	AST_PASS_GATE: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		(ce && accept && !ramp_speed_ok) |=> !(move_valid ? move.pass_through : buf_move.pass_through))
		else $error("pass through despite ramp speed miss");

	AST_REACHED: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		$rose(reached) |-> all_done && in_win)
		else $error("target reached while moving or outside window");

	AST_FERR: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		$rose(ferr_flag) |-> closed_loop && ferr_cnt > ferr_tmo)
		else $error("following error flag without timeout");

	AST_BUF_ISSUE: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
		(ce && issue_buf) |=> move_valid && !buf_valid ##1 !move_valid)
		else $error("buffered move not handed over once");

endmodule

// ---- verification/pph_gen_model.sv ----
`timescale 1ns/1ps
// ==========================================
// profile generator stand-in: runs each issued move for run_len cycles
module pph_gen_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire pph_pkg::pph_move_t move,
	input wire logic move_valid,
	input wire logic [7:0] run_len,
	output logic move_busy,
	output logic move_done,
	output logic [31:0] actual_pos,
	output logic [31:0] demand_pos
);
	logic [7:0] left;

	// demand leads the target so that demand and actual references differ
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 8'h00;
			move_busy <= 1'b0;
			move_done <= 1'b0;
			actual_pos <= 32'h00000000;
			demand_pos <= 32'h00000000;
		end else begin
			move_done <= 1'b0;
			if (move_valid) begin
				left <= run_len;
				move_busy <= 1'b1;
				demand_pos <= move.target + 32'h00000010;
			end else if (left == 8'h01) begin
				left <= 8'h00;
				move_busy <= 1'b0;
				move_done <= 1'b1;
				actual_pos <= move.target;
			end else if (left != 8'h00) begin
				left <= left - 8'h01;
			end
		end
	end
endmodule

// ---- verification/profile_position_command_handler_tb.sv ----
`timescale 1ns/1ps
// ==========================================
// bench top
module profile_position_command_handler_tb;
	localparam int TICK = 8;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, move_valid, halt;
	logic move_busy, move_done, ramp_speed_ok, closed_loop, er;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, actual_pos, demand_pos, follow_err, seed, vel, acc, dec, last, rd, hopt, t, d, base;
	logic [15:0] halt_option;
	logic [7:0] run_len;
	pph_pkg::pph_move_t move;
	pph_pkg::pph_move_t exp_q[$];
	int err_total, total_checks, cyc;

	pph_handler #(.TICK_CYCLES(TICK)) pph_handler_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .move(move), .move_valid(move_valid),
		.halt(halt), .halt_option(halt_option), .move_busy(move_busy), .move_done(move_done),
		.ramp_speed_ok(ramp_speed_ok), .actual_pos(actual_pos), .demand_pos(demand_pos),
		.follow_err(follow_err), .closed_loop(closed_loop));
	pph_gen_model pph_gen_model_inst (.pclk(pclk), .presetn(presetn), .move(move),
		.move_valid(move_valid), .run_len(run_len), .move_busy(move_busy), .move_done(move_done),
		.actual_pos(actual_pos), .demand_pos(demand_pos));

	// ==========================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic pph_pkg::pph_move_t mk(input logic [31:0] tg, input logic p);
		return '{target: tg, velocity: vel, accel: acc, decel: dec, pass_through: p};
	endfunction
	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: word got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_move(input pph_pkg::pph_move_t got, input pph_pkg::pph_move_t exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: move got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		check_word(rd & m, exp);
	endtask
	task automatic wt(input int n);
		repeat (n * TICK) @(posedge pclk);
	endtask
	task automatic set_params();
		vel = xs();
		acc = xs();
		dec = xs();
		wr(pph_pkg::IDX_VELOCITY, vel);
		wr(pph_pkg::IDX_ACCEL, acc);
		wr(pph_pkg::IDX_DECEL, dec);
	endtask
	// start bit held high for two tick periods, then lowered
	task automatic cmd(input logic [31:0] cw, input logic [31:0] tg);
		wr(pph_pkg::IDX_TARGET, tg);
		wr(pph_pkg::IDX_CTRL, cw | 32'h10);
		wt(2);
		wr(pph_pkg::IDX_CTRL, cw);
		wt(2);
	endtask

	// ==========================================
	// clock, timeout and move monitor
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	// every issued move must match the oldest expectation
	always @(posedge pclk) begin
		if (move_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("Error %0t: unexpected move %h", $time, move);
			end else begin
				check_move(move, exp_q.pop_front());
			end
		end
	end

	// ==========================================
	// scenarios
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		ramp_speed_ok = 1'b1;
		follow_err = 32'h00000000;
		closed_loop = 1'b0;
		run_len = 8'h04;
		seed = 32'h0000191F;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc(pph_pkg::IDX_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rc(pph_pkg::IDX_STAT, 32'h00003C00, 32'h00000000);
		rc(pph_pkg::IDX_LIM_MAX, 32'hFFFFFFFF, pph_pkg::LIM_MAX_RST);
		apb(1'b0, 16'h6000, 32'h00000000);
		check_word({31'h0, er}, 32'h00000001);
		check_word(rd, 32'h00000000);
		wr(pph_pkg::IDX_STAT, 32'h0000FFFF);
		// idle at zero inside a zero window with zero dwell: reached after the first tick
		rc(pph_pkg::IDX_STAT, 32'h0000FFFF, 32'h00000400);
		hopt = xs() & 32'h0000FFFF;
		wr(pph_pkg::IDX_HALT_OPT, hopt);
		wr(pph_pkg::IDX_TOL_WIN, 32'h00000000);
		wr(pph_pkg::IDX_DWELL, 32'h00000001);
		wr(pph_pkg::IDX_FERR_WIN, 32'h00000005);
		wr(pph_pkg::IDX_FERR_TMO, 32'h00000001);
		set_params();
		// start bit already high when the mode is entered
		last = xs() & 32'h0000FFFF;
		wr(pph_pkg::IDX_TARGET, last);
		wr(pph_pkg::IDX_CTRL, 32'h00000030);
		exp_q.push_back(mk(last, 1'b0));
		wr(pph_pkg::IDX_OPSEL, 32'h00000001);
		wt(2);
		rc(pph_pkg::IDX_STAT, 32'h00001000, 32'h00001000);
		wr(pph_pkg::IDX_CTRL, 32'h00000020);
		wt(4);
		rc(pph_pkg::IDX_STAT, 32'h00001400, 32'h00000400);
		// a start bit held high starts only once
		last = xs() & 32'h0000FFFF;
		exp_q.push_back(mk(last, 1'b0));
		wr(pph_pkg::IDX_TARGET, last);
		wr(pph_pkg::IDX_CTRL, 32'h00000030);
		wt(2);
		wr(pph_pkg::IDX_TARGET, last ^ 32'h00000055);
		wr(pph_pkg::IDX_CTRL, 32'h00000030);
		wt(2);
		wr(pph_pkg::IDX_CTRL, 32'h00000020);
		wt(2);
		// relative moves for each reference code
		for (int c = 0; c < 3; c++) begin
			d = xs() & 32'h0000FFFF;
			wr(pph_pkg::IDX_POS_OPT, c);
			base = (c == 1) ? last + 32'h00000010 : last;
			last = base + d;
			exp_q.push_back(mk(last, 1'b0));
			cmd(32'h00000060, d);
		end
		wr(pph_pkg::IDX_POS_OPT, 32'h00000000);
		// target outside limits: no acknowledge, limit flag up
		wr(pph_pkg::IDX_LIM_MAX, 32'h00000000);
		wr(pph_pkg::IDX_TARGET, 32'h00000200);
		wr(pph_pkg::IDX_CTRL, 32'h00000030);
		wt(2);
		rc(pph_pkg::IDX_STAT, 32'h00001800, 32'h00000800);
		wr(pph_pkg::IDX_CTRL, 32'h00000020);
		wr(pph_pkg::IDX_LIM_MAX, pph_pkg::LIM_MAX_RST);
		// buffered: one queued with fresh parameters, a third dropped
		run_len <= 8'hFA;
		set_params();
		t = xs() & 32'h0000FFFF;
		exp_q.push_back(mk(t, 1'b1));
		cmd(32'h00000200, t);
		ramp_speed_ok <= 1'b0;
		set_params();
		t = xs() & 32'h0000FFFF;
		exp_q.push_back(mk(t, 1'b0));
		cmd(32'h00000200, t);
		set_params();
		cmd(32'h00000200, xs() & 32'h0000FFFF);
		wt(40);
		wt(40);
		ramp_speed_ok <= 1'b1;
		run_len <= 8'h04;
		// device clears the start bit on acceptance
		wr(pph_pkg::IDX_POS_OPT, 32'h00000010);
		t = xs() & 32'h0000FFFF;
		exp_q.push_back(mk(t, 1'b0));
		wr(pph_pkg::IDX_TARGET, t);
		wr(pph_pkg::IDX_CTRL, 32'h00000030);
		wt(2);
		rc(pph_pkg::IDX_CTRL, 32'h00000010, 32'h00000000);
		wr(pph_pkg::IDX_POS_OPT, 32'h00000000);
		// halt follows bit 8 with the chosen braking option
		wr(pph_pkg::IDX_CTRL, 32'h00000120);
		wt(2);
		check_word({31'h0, halt}, 32'h00000001);
		check_word({16'h0, halt_option}, hopt);
		wr(pph_pkg::IDX_CTRL, 32'h00000020);
		wt(2);
		check_word({31'h0, halt}, 32'h00000000);
		// following error beyond window past the timeout
		closed_loop <= 1'b1;
		follow_err <= 32'h00000006;
		wt(5);
		rc(pph_pkg::IDX_STAT, 32'h00002000, 32'h00002000);
		follow_err <= 32'h00000005;
		wt(3);
		rc(pph_pkg::IDX_STAT, 32'h00002000, 32'h00000000);
		wt(2);
		check_word(32'(exp_q.size()), 32'h00000000);
		report_and_stop();
	end
endmodule
